/* rtl/flash_host_pkg.sv */
// shared constants and types for the parallel flash host controller
package flash_host_pkg;
    localparam int ADDR_W = 22;
    localparam int DATA_W = 8;
    localparam int SECTOR_LSB = 16;
    localparam int SECTOR_W = 6;
    localparam int SYNC_STAGES = 2;
    localparam int CNT_W = 16;
    localparam int CLK_MHZ = 250;
    // pin timings in ns; plain defaults, adjust for the fitted part
    localparam int SELECT_ACCESS_NS = 70;
    localparam int ADDR_SETUP_NS = 10;
    localparam int WE_PULSE_NS = 35;
    localparam int WE_HOLD_NS = 20;
    localparam int RESET_PULSE_MIN_NS = 500;
    localparam int RESET_READ_RECOVERY_NS = 50;
    localparam int READY_NS = 20000;
    // least times round up to whole cycles
    localparam int ACCESS_CYC = (SELECT_ACCESS_NS * CLK_MHZ + 999) / 1000;
    localparam int SETUP_CYC = (ADDR_SETUP_NS * CLK_MHZ + 999) / 1000;
    localparam int WE_CYC = (WE_PULSE_NS * CLK_MHZ + 999) / 1000;
    localparam int HOLD_CYC = (WE_HOLD_NS * CLK_MHZ + 999) / 1000;
    localparam int RESET_CYC = (RESET_PULSE_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int RECOVERY_CYC = (RESET_READ_RECOVERY_NS * CLK_MHZ + 999) / 1000;
    localparam int READY_CYC = (READY_NS * CLK_MHZ + 999) / 1000;
    localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
    localparam logic [ADDR_W-1:0] ADDR_RST = 22'h000000;
    localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
    localparam logic [SECTOR_W-1:0] SECTOR_RST = 6'h00;

    typedef enum logic [1:0] {
        OP_READ,
        OP_WRITE,
        OP_RESET
    } op_t;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_RD_ACCESS,
        ST_WR_SETUP,
        ST_WR_PULSE,
        ST_WR_HOLD,
        ST_RST_PULSE,
        ST_RST_RECOVER,
        ST_RST_READY
    } state_t;
endpackage

/* rtl/pin_sync_if.sv */
// carries a raw pin group and its synchronised copy
`timescale 1ns/100ps
`default_nettype none
interface pin_sync_if #(parameter int W = 1);
    logic [W-1:0] raw;
    logic [W-1:0] sampled;
    modport sync_side (input raw, output sampled);
    modport user_side (output raw, input sampled);
endinterface
`default_nettype wire

/* rtl/pin_sync.sv */
// two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/100ps
`default_nettype none
module pin_sync
    import flash_host_pkg::*;
#(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk,
    input wire logic sys_rst,
    pin_sync_if.sync_side pins
);
    logic [W-1:0] meta;
    logic [W-1:0] stable;

    // meta feeds only the second flop
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            meta <= RST_VAL;
            stable <= RST_VAL;
        end else begin
            meta <= pins.raw;
            stable <= meta;
        end
    end

    assign pins.sampled = stable;
endmodule
`default_nettype wire

/* rtl/flash_host.sv */
// host-side controller driving a byte-wide parallel nor flash over its pins
// How it works
// R1 - read: select and output gate low, strobe high
// R2 - device starts in array read after reset
// R3 - device returns array data until command written
// R4 - write: strobe and select low, gate high
// R5 - erase targets sector, several, or whole chip
// R6 - sector index is address bits 21..16
// R7 - bad sequence returns device to array read
// R8 - autoselect sequence makes reads return identifiers
// R9 - reads during program or erase return status
// R10 - select and reset high gives standby, floating
// R11 - deselect does not stop running operation
// R12 - reset pulse aborts, floats, returns to read
// R13 - reset low also means standby
// R14 - restart operation interrupted by reset
// R15 - busy stays low until internal reset done
// R16 - wait recovery after reset before reading
// R17 - output gate high floats device outputs
// R18 - address on later fall, data earlier rise
// R19 - writes ignored unless select, strobe low, gate high
// R20 - 22-bit byte address, 8-bit two-way data
`timescale 1ns/100ps
`default_nettype none
module flash_host
    import flash_host_pkg::*;
#(
    parameter int READY_WAIT_CYC = READY_CYC
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic req,
    input wire op_t req_op,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic [DATA_W-1:0] req_wdata,
    output logic busy,
    output logic done,
    output logic [DATA_W-1:0] rdata,
    output logic [SECTOR_W-1:0] sector_index,
    output logic device_busy,
    output logic redo_needed,
    input wire logic redo_clear,
    output logic flash_ce_n,
    output logic flash_oe_n,
    output logic flash_we_n,
    output logic flash_reset_n,
    output logic [ADDR_W-1:0] flash_addr,
    input wire logic [DATA_W-1:0] data_pins_in,
    output logic [DATA_W-1:0] data_pins_out,
    output logic data_pins_oe_n,
    input wire logic ready_busy_n
);
    state_t state, next_state;
    logic [CNT_W-1:0] cnt, next_cnt;
    logic next_ce_n, next_oe_n, next_we_n, next_reset_n, next_data_oe_n, next_done;
    logic next_redo;
    logic [DATA_W-1:0] next_rdata;

    pin_sync_if #(.W(DATA_W)) data_sync ();
    pin_sync_if #(.W(1)) rb_sync ();
    assign data_sync.raw = data_pins_in;
    assign rb_sync.raw = ready_busy_n;

    pin_sync #(.W(DATA_W), .RST_VAL(DATA_RST)) u_data_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .pins(data_sync)
    );
    pin_sync #(.W(1), .RST_VAL(1'b1)) u_rb_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .pins(rb_sync)
    );

    wire logic dev_ready = rb_sync.sampled[0];
    wire logic take = req && (state == ST_IDLE);
    wire logic cnt_done = (cnt == CNT_ZERO);
    wire logic [CNT_W-1:0] cnt_dec = cnt - 16'h0001;
    // the synchroniser adds its latency on top of the access time
    wire logic [CNT_W-1:0] rd_load = CNT_W'(ACCESS_CYC + SYNC_STAGES - 1);
    wire logic [CNT_W-1:0] ready_load = CNT_W'(READY_WAIT_CYC - 1);

    always_comb begin
        next_state = state;
        next_cnt = cnt_done ? cnt : cnt_dec;
        next_ce_n = 1'b1;
        next_oe_n = 1'b1;
        next_we_n = 1'b1;
        next_reset_n = 1'b1;
        next_data_oe_n = 1'b1;
        next_done = 1'b0;
        next_rdata = rdata;
        next_redo = redo_needed && !redo_clear;
        unique case (state)
            ST_IDLE: begin
                if (take) begin
                    unique case (req_op)
                        OP_READ: begin
                            next_state = ST_RD_ACCESS;
                            next_cnt = rd_load;
                            next_ce_n = 1'b0; // R1
                            next_oe_n = 1'b0; // R1
                        end
                        OP_WRITE: begin
                            next_state = ST_WR_SETUP;
                            next_cnt = CNT_W'(SETUP_CYC - 1);
                            next_ce_n = 1'b0; // R4
                            next_data_oe_n = 1'b0;
                        end
                        default: begin
                            next_state = ST_RST_PULSE;
                            next_cnt = CNT_W'(RESET_CYC - 1);
                            next_reset_n = 1'b0;
                            // an embedded operation cut short must be reissued
                            next_redo = !dev_ready || (redo_needed && !redo_clear); // R14
                        end
                    endcase
                end
            end
            ST_RD_ACCESS: begin
                next_ce_n = 1'b0;
                next_oe_n = 1'b0;
                if (cnt_done) begin
                    next_state = ST_IDLE;
                    next_rdata = data_sync.sampled;
                    next_done = 1'b1;
                    next_ce_n = 1'b1;
                    next_oe_n = 1'b1;
                end
            end
            ST_WR_SETUP: begin
                next_ce_n = 1'b0;
                next_data_oe_n = 1'b0;
                if (cnt_done) begin
                    next_state = ST_WR_PULSE;
                    next_cnt = CNT_W'(WE_CYC - 1);
                    next_we_n = 1'b0; // R4
                end
            end
            ST_WR_PULSE: begin
                next_ce_n = 1'b0;
                next_data_oe_n = 1'b0;
                next_we_n = 1'b0;
                if (cnt_done) begin
                    // strobe rises first so the data edge is the strobe's
                    next_state = ST_WR_HOLD;
                    next_cnt = CNT_W'(HOLD_CYC - 1);
                    next_we_n = 1'b1;
                end
            end
            ST_WR_HOLD: begin
                next_ce_n = 1'b0;
                next_data_oe_n = 1'b0;
                if (cnt_done) begin
                    next_state = ST_IDLE;
                    next_done = 1'b1;
                    next_ce_n = 1'b1;
                    next_data_oe_n = 1'b1;
                end
            end
            ST_RST_PULSE: begin
                next_reset_n = 1'b0;
                if (cnt_done) begin
                    next_state = ST_RST_RECOVER;
                    next_cnt = CNT_W'(RECOVERY_CYC - 1);
                    next_reset_n = 1'b1;
                end
            end
            ST_RST_RECOVER: begin
                if (cnt_done) begin // R16
                    next_state = ST_RST_READY;
                    next_cnt = ready_load;
                end
            end
            ST_RST_READY: begin
                // bounded wait so a stuck busy line cannot hang the host
                if (dev_ready || cnt_done) begin
                    next_state = ST_IDLE;
                    next_done = 1'b1;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state <= ST_IDLE;
            cnt <= CNT_ZERO;
            flash_ce_n <= 1'b1;
            flash_oe_n <= 1'b1;
            flash_we_n <= 1'b1;
            flash_reset_n <= 1'b1;
            data_pins_oe_n <= 1'b1;
            done <= 1'b0;
            busy <= 1'b0;
            rdata <= DATA_RST;
            redo_needed <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            flash_ce_n <= next_ce_n;
            flash_oe_n <= next_oe_n;
            flash_we_n <= next_we_n;
            flash_reset_n <= next_reset_n;
            data_pins_oe_n <= next_data_oe_n;
            done <= next_done;
            busy <= (next_state != ST_IDLE);
            rdata <= next_rdata;
            redo_needed <= next_redo;
        end
    end

    // address and data held for the whole cycle so both latch edges see them
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            flash_addr <= ADDR_RST;
            data_pins_out <= DATA_RST;
            sector_index <= SECTOR_RST;
            device_busy <= 1'b0;
        end else begin
            if (take) begin
                flash_addr <= req_addr;
                data_pins_out <= req_wdata;
                sector_index <= req_addr[SECTOR_LSB +: SECTOR_W]; // R6
            end
            device_busy <= !dev_ready;
        end
    end

    // helper counters watched only by the checks below
    logic [CNT_W-1:0] low_cnt, high_cnt;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            low_cnt <= CNT_ZERO;
            // no pulse issued yet, so start as long recovered
            high_cnt <= ~CNT_ZERO;
        end else begin
            low_cnt <= flash_reset_n ? CNT_ZERO : low_cnt + 16'h0001;
            high_cnt <= !flash_reset_n ? CNT_ZERO :
                        (high_cnt == 16'hFFFF ? high_cnt : high_cnt + 16'h0001);
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    AST_READ_LEVELS: assert property ((!flash_ce_n && !flash_oe_n) |-> // R1
        (flash_we_n && flash_reset_n && data_pins_oe_n))
        else $error("read cycle without strobe high or with data driven");
    AST_WRITE_LEVELS: assert property (!flash_we_n |-> // R4
        (!flash_ce_n && flash_oe_n && !data_pins_oe_n))
        else $error("write strobe low without select low and gate high");
    AST_WRITE_DATA_STABLE: assert property ($rose(flash_we_n) |-> // R4
        (!flash_ce_n && !data_pins_oe_n && $stable(data_pins_out)))
        else $error("data or select moved at the strobe's rising edge");
    AST_RESET_WIDTH: assert property ($rose(flash_reset_n) |-> // R12
        ($past(low_cnt) >= CNT_W'(RESET_CYC - 1)))
        else $error("reset pulse shorter than its minimum");
    AST_READ_RECOVERY: assert property ($fell(flash_oe_n) |-> // R16
        (high_cnt >= CNT_W'(RECOVERY_CYC)))
        else $error("read started too soon after reset release");
    AST_REDO_FLAG: assert property (($fell(flash_reset_n) && !$past(dev_ready)) |-> // R14
        redo_needed)
        else $error("interrupted operation not flagged for restart");
    AST_READ_DONE: assert property (($rose(flash_oe_n) && flash_ce_n // R1
        && $past(state) == ST_RD_ACCESS) |-> done)
        else $error("read completion not signalled as select drops");

    COV_READ: cover property ((state == ST_RD_ACCESS) ##1 done);
    COV_WRITE: cover property ((state == ST_WR_HOLD) ##1 done);
    COV_RESET_BUSY: cover property ((state == ST_RST_READY) && !dev_ready);
    COV_REDO: cover property ($rose(redo_needed));
endmodule
`default_nettype wire

/* dv/flash_model.sv */
// behavioural parallel flash device facing the host controller
`timescale 1ns/100ps
`default_nettype none
module flash_model
    import flash_host_pkg::*;
#(
    parameter logic [7:0] CMD_IDENT = 8'h90,
    parameter logic [7:0] CMD_ERASE = 8'h30,
    parameter logic [7:0] IDENT_CODE = 8'h5A, // arbitrary value
    parameter logic [7:0] STATUS_CODE = 8'h08,
    parameter int BUSY_CYC = 300,
    parameter int SETTLE_CYC = 10
) (
    input wire logic clk,
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic reset_n,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] din,
    output logic [DATA_W-1:0] dout,
    output logic ready_busy_n
);
    logic ident = 1'b0;
    int busy_cnt = 0;
    logic [DATA_W-1:0] last = 8'h00;
    logic wr_q = 1'b0;
    wire wr_act = !ce_n && !we_n && oe_n && reset_n;
    wire rd_act = !ce_n && !oe_n && we_n && reset_n;
    wire [7:0] arr = addr[7:0] ^ {2'b00, addr[21:16]};
    wire [7:0] dout_v = busy_cnt > 0 ? STATUS_CODE : ident ? IDENT_CODE : arr;
    // data taken as the write ends, whichever strobe rises first; one process owns the state
    always @(posedge clk) begin
        wr_q <= wr_act;
        if (reset_n === 1'b0) begin
            ident <= 1'b0;
            if (busy_cnt > 0) busy_cnt <= SETTLE_CYC;
        end else if (busy_cnt > 0) begin
            busy_cnt <= busy_cnt - 1;
        end else if (wr_q && !wr_act) begin
            ident <= (din == CMD_IDENT);
            if (din == CMD_ERASE) busy_cnt <= BUSY_CYC;
        end
        if (rd_act) last <= dout_v;
    end
    assign ready_busy_n = (busy_cnt == 0);
    // floated bus: no pull, so show the inverse of the last value
    assign dout = rd_act ? dout_v : ~last;
endmodule
`default_nettype wire

/* dv/flash_host_tb.sv */
// self-checking bench for the parallel flash host controller
`timescale 1ns/100ps
`default_nettype none
module flash_host_tb;
    import flash_host_pkg::*;
    localparam logic [7:0] IDENT = 8'h5A; // arbitrary value
    localparam logic [7:0] STAT = 8'h08;
    logic clk, sys_rst, req, redo_clear;
    op_t req_op;
    logic [ADDR_W-1:0] req_addr, flash_addr;
    logic [DATA_W-1:0] req_wdata, rdata, data_pins_out, dev_out;
    logic [SECTOR_W-1:0] sector_index;
    logic busy, done, device_busy, redo_needed, ready_busy_n, data_pins_oe_n;
    logic flash_ce_n, flash_oe_n, flash_we_n, flash_reset_n;
    int n_errors = 0;
    int checks_done = 0;
    wire [DATA_W-1:0] bus = data_pins_oe_n ? dev_out : data_pins_out;
    flash_host #(.READY_WAIT_CYC(20)) dut (.clk(clk), .sys_rst(sys_rst), .req(req),
        .req_op(req_op), .req_addr(req_addr), .req_wdata(req_wdata), .busy(busy),
        .done(done), .rdata(rdata), .sector_index(sector_index),
        .device_busy(device_busy), .redo_needed(redo_needed), .redo_clear(redo_clear),
        .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n),
        .flash_reset_n(flash_reset_n), .flash_addr(flash_addr), .data_pins_in(bus),
        .data_pins_out(data_pins_out), .data_pins_oe_n(data_pins_oe_n),
        .ready_busy_n(ready_busy_n));
    flash_model #(.IDENT_CODE(IDENT), .STATUS_CODE(STAT), .SETTLE_CYC(20)) dev (.clk(clk),
        .ce_n(flash_ce_n), .oe_n(flash_oe_n), .we_n(flash_we_n), .reset_n(flash_reset_n),
        .addr(flash_addr), .din(bus), .dout(dev_out), .ready_busy_n(ready_busy_n));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // one request; strobe pairing watched every cycle while selected
    task automatic run_op(input op_t op, input logic [21:0] a, input logic [7:0] d,
        output int cyc);
        @(posedge clk);
        #1 req = 1'b1;
        req_op = op;
        req_addr = a;
        req_wdata = d;
        @(posedge clk);
        #1 req = 1'b0;
        cyc = 1;
        check("busy after take", busy, 1);
        while (done !== 1'b1 && cyc < 2000) begin
            if (flash_ce_n === 1'b0)
                check("strobes", {flash_we_n | flash_oe_n, flash_oe_n | data_pins_oe_n}, 3);
            @(posedge clk);
            #1 cyc++;
        end
        check("done", done, 1);
        check("idle after done", busy, 0);
        check("standby select", flash_ce_n, 1);
    endtask
    task automatic read_exp(input logic [21:0] a, input logic [7:0] e);
        int c;
        run_op(OP_READ, a, 8'h00, c);
        check("read data", rdata, e);
        check("read cycles", c, ACCESS_CYC + SYNC_STAGES + 1);
        check("sector", sector_index, a[21:16]);
    endtask
    task automatic write_cmd(input logic [21:0] a, input logic [7:0] d);
        int c;
        run_op(OP_WRITE, a, d, c);
        check("write cycles", c, SETUP_CYC + WE_CYC + HOLD_CYC + 1);
    endtask
    task automatic t_read_array();
        logic [21:0] al[5] = '{22'h000000, 22'h00FFFF, 22'h010000, 22'h2B1234, 22'h3FFFFF};
        foreach (al[i]) read_exp(al[i], al[i][7:0] ^ {2'b00, al[i][21:16]});
        $display("test read_array done");
    endtask
    task automatic t_ident();
        write_cmd(22'h000555, 8'h90);
        read_exp(22'h000001, IDENT);
        read_exp(22'h000002, IDENT);
        write_cmd(22'h000555, 8'h55);
        read_exp(22'h000002, 8'h02);
        $display("test ident done");
    endtask
    task automatic wait_ready();
        int k = 0;
        while (device_busy !== 1'b0 && k < 1000) begin
            @(posedge clk);
            #1 k++;
        end
        check("device ready", device_busy, 0);
    endtask
    task automatic t_status();
        write_cmd(22'h050000, 8'h30);
        read_exp(22'h050010, STAT);
        check("busy while deselected", device_busy, 1);
        wait_ready();
        read_exp(22'h050010, 8'h15);
        $display("test status done");
    endtask
    task automatic t_reset();
        int c;
        // the spare operation code also issues a reset
        run_op(op_t'(2'b11), 22'h000000, 8'h00, c);
        check("idle reset redo", redo_needed, 0);
        check("reset cycles", c, RESET_CYC + RECOVERY_CYC + 2);
        write_cmd(22'h3C0000, 8'h30);
        read_exp(22'h3C0000, STAT);
        run_op(OP_RESET, 22'h000000, 8'h00, c);
        check("redo flag", redo_needed, 1);
        check("ready after reset", device_busy, 0);
        read_exp(22'h3C0004, 8'h38);
        @(posedge clk);
        #1 redo_clear = 1'b1;
        @(posedge clk);
        #1 redo_clear = 1'b0;
        check("redo cleared", redo_needed, 0);
        $display("test reset done");
    endtask
    initial begin
        sys_rst = 1'b1;
        req = 1'b0;
        req_op = OP_READ;
        req_addr = '0;
        req_wdata = '0;
        redo_clear = 1'b0;
        repeat (8) @(posedge clk);
        #1 sys_rst = 1'b0;
        t_read_array();
        t_ident();
        t_status();
        t_reset();
        tally_and_finish();
    end
    // whole run needs under 1000 cycles
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
